// ===== src/drpf_defs.svh
`ifndef DRPF_DEFS_SVH
`define DRPF_DEFS_SVH

// clock rate of the controller
`define DRPF_CLK_MHZ 125

// refresh geometry
`define DRPF_ROWS 32
`define DRPF_ROW_W 5
`define DRPF_UPPER_W 7

// times in nanoseconds, as printed or chosen
`define DRPF_PRETRIG_NS 3000
`define DRPF_STROBE_NS 500
`define DRPF_DIST_NS 62500
`define DRPF_BURST_NS 2000000
`define DRPF_RD_NS 300
`define DRPF_WR_NS 210
`define DRPF_PRE_NS 100

// least times round up, intervals round down
`define DRPF_PRETRIG_CYC ((`DRPF_PRETRIG_NS * `DRPF_CLK_MHZ + 999) / 1000)
`define DRPF_STROBE_CYC ((`DRPF_STROBE_NS * `DRPF_CLK_MHZ + 999) / 1000)
`define DRPF_RD_CYC ((`DRPF_RD_NS * `DRPF_CLK_MHZ + 999) / 1000)
`define DRPF_WR_CYC ((`DRPF_WR_NS * `DRPF_CLK_MHZ + 999) / 1000)
`define DRPF_PRE_CYC ((`DRPF_PRE_NS * `DRPF_CLK_MHZ + 999) / 1000)
`define DRPF_DIST_CYC ((`DRPF_DIST_NS * `DRPF_CLK_MHZ) / 1000)
`define DRPF_BURST_CYC ((`DRPF_BURST_NS * `DRPF_CLK_MHZ) / 1000)

// register byte offsets
`define DRPF_OFS_CTRL 8'h00
`define DRPF_OFS_STATUS 8'h04
`define DRPF_OFS_UPPER 8'h08
`define DRPF_OFS_COUNT 8'h0C

// control register fields
`define DRPF_CTRL_EN 0
`define DRPF_CTRL_BURST 1
`define DRPF_CTRL_ABORT 2
`define DRPF_CTRL_CLRABT 3

// status register fields
`define DRPF_ST_BAT 0
`define DRPF_ST_HOLD 1
`define DRPF_ST_BUSY 2
`define DRPF_ST_ABORTED 3
`define DRPF_ST_ROW_LSB 8
`define DRPF_ST_PEND_LSB 16

// reset values
`define DRPF_CTRL_RST 2'b01
`define DRPF_UPPER_RST 7'h00

`endif

// ===== src/drpf_pkg.sv
package drpf_pkg;

   // refresh cycle sequencer, gray coded along its path
   typedef enum logic [1:0] {
      RF_IDLE  = 2'b00,
      RF_READ  = 2'b01,
      RF_WRITE = 2'b11,
      RF_PRECH = 2'b10
   } drpf_rf_state_type;

endpackage : drpf_pkg

// ===== src/drpf_one_shot.sv
`timescale 1ns/1ps
// retriggerless monostable: a trigger starts a pulse of CYCLES clocks
module drpf_one_shot #(
   parameter int CYCLES = 8
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // trigger and pulse
   input wire logic trigger,
   output logic active,
   output logic donePulse
);

   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic run;
      logic [CW-1:0] cnt;
      logic done;
   } drpf_shot_type;

   drpf_shot_type s;
   drpf_shot_type next_s;

   // count down; a trigger during a pulse is ignored, like the cmos part
   always_comb begin
      next_s = s;
      next_s.done = 1'b0;
      if (s.run) begin
         if (s.cnt == CW'(1)) begin
            next_s.run = 1'b0;
            next_s.done = 1'b1;
         end
         next_s.cnt = s.cnt - CW'(1);
      end else if (trigger) begin
         next_s.run = 1'b1;
         next_s.cnt = CW'(CYCLES);
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign active = s.run;
   assign donePulse = s.done;

endmodule : drpf_one_shot

// ===== src/drpf_refresh_ctrl.sv
// Function
// - every row refreshed within each 2 ms
// - upper address bits held steady during refresh, unless written as the sequencer leaves RF_IDLE
// - burst mode: 32 cycles every 2 ms
// - distributed mode: one cycle every 62.5 us
// - abortable read-modify-write refresh, chip select high
// - refresh works in operating and standby modes
// - supply loss synchronised before changing mode
// - refresh clock edge starts 3 us pretrigger
// - pretrigger end starts 500 ns standby strobe
// - pretrigger sets hold flag blocking mode change
// - strobe end clears hold flag
// - mode flag sampled by memory clock, jk
// - standby flag selects internal strobe, refresh only
// - one strobe source drives at a time
// - processor access strobes only the addressed bank
// - two banks, each with own strobe
// - standby removes power from unneeded logic
// - refresh is write with chip select high
`timescale 1ns/1ps
`include "drpf_defs.svh"
module drpf_refresh_ctrl
   import drpf_pkg::*;
#(
   parameter int DIST_CYCLES = `DRPF_DIST_CYC,
   parameter int BURST_CYCLES = `DRPF_BURST_CYC,
   parameter int PRETRIG_CYCLES = `DRPF_PRETRIG_CYC,
   parameter int STROBE_CYCLES = `DRPF_STROBE_CYC,
   parameter int ROWS = `DRPF_ROWS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // system timing and supply
   input wire logic memClk,
   input wire logic refreshClk,
   input wire logic supplyLoss,
   // processor access request
   input wire logic cpuReq,
   input wire logic cpuWrite,
   input wire logic [12:0] cpuAddr,
   output logic cpuGrant,
   // dram array pins
   output logic [11:0] memAddr,
   output logic [1:0] ceBank,
   output logic ceStbyOe,
   output logic ceClkOe,
   output logic readWrite,
   output logic chipSelN,
   // standby power switch
   output logic auxPowerEn
);

   localparam int TW = 32;
   localparam int RW = `DRPF_ROW_W;
   localparam int UW = `DRPF_UPPER_W;

   typedef struct packed {
      logic [1:0] lossSync;
      logic memClkPrev;
      logic refClkPrev;
      logic modeHold;
      logic batFlag;
      drpf_rf_state_type rfState;
      logic [7:0] phaseCnt;
      logic [TW-1:0] tickCnt;
      logic [5:0] pendCnt;
      logic [RW-1:0] rowCnt;
      logic enable;
      logic burstMode;
      logic abortReq;
      logic abortSticky;
      logic [UW-1:0] upperBits;
      logic [15:0] doneCnt;
      logic wrPend;
      logic [7:0] wrAddr;
      logic [31:0] rdData;
      logic [11:0] addrOut;
      logic [1:0] ceOut;
      logic stbyOe;
      logic clkOe;
      logic rwOut;
      logic csN;
      logic [12:0] cpuAddrLat;
      logic cpuWr;
      logic cpuBusy;
   } drpf_state_type;

   drpf_state_type s;
   drpf_state_type next_s;

   logic refRise;
   logic memRise;
   logic preActive;
   logic preDone;
   logic strobeActive;
   logic strobeDone;
   logic busAccess;
   logic wordOk;
   logic periodHit;

   // bank decode, used by the processor strobes only
   function automatic logic [1:0] bankSel(input logic bankBit);
      bankSel = bankBit ? 2'b10 : 2'b01;
   endfunction : bankSel

   // edges of the sampled clocks
   assign refRise = refreshClk & ~s.refClkPrev;
   assign memRise = memClk & ~s.memClkPrev;

   // pretrigger and standby strobe monostables
   drpf_one_shot #(.CYCLES(PRETRIG_CYCLES)) uPretrig (
      .clk(clk),
      .rst(rst),
      .trigger(refRise),
      .active(preActive),
      .donePulse(preDone)
   );

   drpf_one_shot #(.CYCLES(STROBE_CYCLES)) uStrobe (
      .clk(clk),
      .rst(rst),
      .trigger(preDone),
      .active(strobeActive),
      .donePulse(strobeDone)
   );

   // ahb address phase qualification; only whole words are honoured
   assign busAccess = hsel & hready & htrans[1];
   assign wordOk = (hsize == 3'b010) & (haddr[1:0] == 2'b00);
   assign periodHit = s.tickCnt >= TW'(s.burstMode ? BURST_CYCLES : DIST_CYCLES) - TW'(1);

   // processor gets the array only when no refresh runs or waits
   assign cpuGrant = cpuReq & ~s.batFlag & (s.rfState == RF_IDLE) & (s.pendCnt == 6'd0);

   // next-state logic for the whole controller
   always_comb begin
      next_s = s;
      next_s.lossSync = {s.lossSync[0], supplyLoss};
      next_s.memClkPrev = memClk;
      next_s.refClkPrev = refreshClk;

      // hold flag: set by the pretrigger, cleared when the strobe ends
      if (strobeDone) begin
         next_s.modeHold = 1'b0;
      end
      if (refRise) begin
         next_s.modeHold = 1'b1;
      end

      // jk mode flip-flop on the memory clock; frozen while a refresh or access is near,
      // starting or active, so a switch can never cut a cycle that begins at this edge
      if (memRise && !s.modeHold && !preActive && !strobeActive
          && s.rfState == RF_IDLE && s.pendCnt == 6'd0 && !s.cpuBusy && !cpuGrant) begin
         next_s.batFlag = s.lossSync[1];
      end

      // refresh interval timer, operating mode only
      if (s.enable && !s.batFlag) begin
         if (periodHit) begin
            next_s.tickCnt = '0;
            if (s.burstMode) begin
               next_s.pendCnt = 6'(ROWS);
            end else if (s.pendCnt != 6'h3F) begin
               next_s.pendCnt = s.pendCnt + 6'd1;
            end
         end else begin
            next_s.tickCnt = s.tickCnt + TW'(1);
         end
      end else begin
         next_s.tickCnt = '0;
      end

      // default pin values: array idle, upper bits parked
      next_s.addrOut = {s.upperBits, s.rowCnt};
      next_s.ceOut = 2'b00;
      next_s.rwOut = 1'b1;
      next_s.csN = 1'b1;
      next_s.stbyOe = s.batFlag;
      next_s.clkOe = ~s.batFlag;

      // refresh sequencer for operating mode
      case (s.rfState)
         RF_IDLE: begin
            next_s.phaseCnt = '0;
            if (!s.batFlag && s.pendCnt != 6'd0 && !s.cpuBusy) begin
               next_s.rfState = RF_READ;
               next_s.ceOut = 2'b11;
            end
         end
         RF_READ: begin
            // read half: chip select high so the array may be left without harm
            next_s.ceOut = 2'b11;
            next_s.phaseCnt = s.phaseCnt + 8'd1;
            if (s.abortReq) begin
               next_s.ceOut = 2'b00;
               next_s.abortReq = 1'b0;
               next_s.abortSticky = 1'b1;
               next_s.phaseCnt = '0;
               next_s.rfState = RF_PRECH;
            end else if (s.phaseCnt >= 8'(`DRPF_RD_CYC - 1)) begin
               next_s.phaseCnt = '0;
               next_s.rwOut = 1'b0;
               next_s.rfState = RF_WRITE;
            end
         end
         RF_WRITE: begin
            // write-back of the inverted row; past this point no abort
            next_s.ceOut = 2'b11;
            next_s.rwOut = 1'b0;
            next_s.phaseCnt = s.phaseCnt + 8'd1;
            if (s.phaseCnt >= 8'(`DRPF_WR_CYC - 1)) begin
               next_s.ceOut = 2'b00;
               next_s.rwOut = 1'b1;
               next_s.phaseCnt = '0;
               next_s.rowCnt = s.rowCnt + RW'(1);
               next_s.pendCnt = s.pendCnt - 6'd1;
               next_s.doneCnt = s.doneCnt + 16'd1;
               next_s.rfState = RF_PRECH;
            end
         end
         RF_PRECH: begin
            // chip enable low long enough to precharge before the next cycle
            next_s.phaseCnt = s.phaseCnt + 8'd1;
            if (s.phaseCnt >= 8'(`DRPF_PRE_CYC - 1)) begin
               next_s.phaseCnt = '0;
               next_s.rfState = RF_IDLE;
            end
         end
         default: begin
            next_s.rfState = RF_IDLE;
         end
      endcase

      // an abort asked for outside the read half has nothing to cut
      if (s.rfState != RF_READ) begin
         next_s.abortReq = 1'b0;
      end

      // processor access: memory clock gated onto the addressed bank only
      if (cpuGrant) begin
         next_s.cpuBusy = 1'b1;
         next_s.cpuAddrLat = cpuAddr;
         next_s.cpuWr = cpuWrite;
      end else if (!cpuReq) begin
         next_s.cpuBusy = 1'b0;
      end
      if (s.cpuBusy && !s.batFlag) begin
         next_s.addrOut = s.cpuAddrLat[11:0];
         next_s.ceOut = memClk ? bankSel(s.cpuAddrLat[12]) : 2'b00;
         next_s.rwOut = ~s.cpuWr;
         next_s.csN = 1'b0;
      end

      // standby: refresh only, strobe from the monostable on both banks
      if (s.batFlag) begin
         next_s.ceOut = {2{strobeActive}};
         next_s.rwOut = 1'b0;
         next_s.csN = 1'b1;
         next_s.abortReq = 1'b0;
         if (strobeDone) begin
            next_s.rowCnt = s.rowCnt + RW'(1);
            next_s.doneCnt = s.doneCnt + 16'd1;
         end
      end

      // ahb data phase of a write; software abort is only taken here
      next_s.wrPend = busAccess & hwrite & wordOk;
      next_s.wrAddr = haddr;
      if (s.wrPend) begin
         if (s.wrAddr == `DRPF_OFS_CTRL) begin
            next_s.enable = hwdata[`DRPF_CTRL_EN];
            next_s.burstMode = hwdata[`DRPF_CTRL_BURST];
            if (hwdata[`DRPF_CTRL_ABORT] && s.rfState == RF_READ) begin
               next_s.abortReq = 1'b1;
            end
            if (hwdata[`DRPF_CTRL_CLRABT] && !(s.rfState == RF_READ && s.abortReq)) begin
               next_s.abortSticky = 1'b0;
            end
         end else if (s.wrAddr == `DRPF_OFS_UPPER) begin
            // a new upper value is dropped while a refresh or standby strobe is in flight
            if (s.rfState == RF_IDLE && !strobeActive) begin
               next_s.upperBits = hwdata[UW-1:0];
            end
         end else if (s.wrAddr == `DRPF_OFS_COUNT) begin
            next_s.doneCnt = 16'd0;
         end
      end

      // ahb read data, registered at the address phase
      next_s.rdData = 32'h0000_0000;
      if (busAccess && !hwrite && wordOk) begin
         if (haddr == `DRPF_OFS_CTRL) begin
            next_s.rdData[`DRPF_CTRL_EN] = s.enable;
            next_s.rdData[`DRPF_CTRL_BURST] = s.burstMode;
         end else if (haddr == `DRPF_OFS_STATUS) begin
            next_s.rdData[`DRPF_ST_BAT] = s.batFlag;
            next_s.rdData[`DRPF_ST_HOLD] = s.modeHold;
            next_s.rdData[`DRPF_ST_BUSY] = (s.rfState != RF_IDLE) | strobeActive;
            next_s.rdData[`DRPF_ST_ABORTED] = s.abortSticky;
            next_s.rdData[`DRPF_ST_ROW_LSB +: RW] = s.rowCnt;
            next_s.rdData[`DRPF_ST_PEND_LSB +: 6] = s.pendCnt;
         end else if (haddr == `DRPF_OFS_UPPER) begin
            next_s.rdData[UW-1:0] = s.upperBits;
         end else if (haddr == `DRPF_OFS_COUNT) begin
            next_s.rdData[15:0] = s.doneCnt;
         end
      end
   end

   // single register for all state but the two monostables; reset leaves the array idle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s <= '0;
         s.rfState <= RF_IDLE;
         s.enable <= 1'b1;
         s.burstMode <= 1'b0;
         s.upperBits <= `DRPF_UPPER_RST;
         s.rwOut <= 1'b1;
         s.csN <= 1'b1;
         s.clkOe <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // outputs; bus always answers at once and okay
   assign hrdata = s.rdData;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign memAddr = s.addrOut;
   assign ceBank = s.ceOut;
   assign ceStbyOe = s.stbyOe;
   assign ceClkOe = s.clkOe;
   assign readWrite = s.rwOut;
   assign chipSelN = s.csN;
   assign auxPowerEn = ~s.batFlag;

endmodule : drpf_refresh_ctrl

// ===== sim/drpf_refresh_ctrl_assertions.sv
`timescale 1ns/1ps
module drpf_refresh_ctrl_chk #(
   parameter int PRETRIG_CYCLES = 375,
   parameter int STROBE_CYCLES = 63
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // watched ports
   input wire logic refreshClk,
   input wire logic cpuGrant,
   input wire logic [11:0] memAddr,
   input wire logic [1:0] ceBank,
   input wire logic ceStbyOe,
   input wire logic ceClkOe,
   input wire logic readWrite,
   input wire logic chipSelN,
   input wire logic auxPowerEn
);
   // trigger sync and one-shot hand-off cost a few cycles, so allow slack
   localparam int PRE_LO = PRETRIG_CYCLES;
   localparam int PRE_HI = PRETRIG_CYCLES + 8;
   logic [15:0] strobeLen;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // length of the running standby strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         strobeLen <= 16'h0000;
      end else begin
         strobeLen <= (ceStbyOe && ceBank != 2'b00) ? strobeLen + 16'h0001 : 16'h0000;
      end
   end
   chk_source_exclusive: assert property (ceClkOe != ceStbyOe)
      else $error("strobe sources not exclusive");
   chk_cpu_waits: assert property ((ceBank == 2'b11 && chipSelN) |-> !cpuGrant)
      else $error("processor granted during refresh");
   chk_upper_steady: assert property (($rose(ceBank[1]) && chipSelN && ceClkOe)
      |=> $stable(memAddr) [*8])
      else $error("address moved during refresh");
   chk_read_first: assert property (($rose(ceBank[0]) && chipSelN && ceClkOe)
      |-> readWrite [*8])
      else $error("refresh write-back too early");
   chk_standby_write: assert property ((ceStbyOe && ceBank != 2'b00) |-> (!readWrite && chipSelN))
      else $error("standby strobe not a refresh");
   chk_strobe_len: assert property ((ceStbyOe && $fell(ceBank[0]))
      |-> strobeLen == 16'(STROBE_CYCLES))
      else $error("standby strobe length wrong");
   chk_pretrig_delay: assert property (($rose(refreshClk) && ceStbyOe)
      |-> ##[PRE_LO:PRE_HI] $rose(ceBank[0]))
      else $error("strobe not after pretrigger");
   // power switch follows the mode flag, the strobe source one clock later
   chk_aux_power: assert property ($past(auxPowerEn) == !ceStbyOe)
      else $error("aux power not following mode");
   chk_mode_locked: assert property (($past(ceBank) != 2'b00 && ceBank != 2'b00 && chipSelN)
      |-> $stable(ceStbyOe))
      else $error("mode changed inside refresh");
   chk_bank_decode: assert property ((!chipSelN && ceClkOe) |-> ceBank != 2'b11)
      else $error("both banks strobed for access");
   // main scenarios
   cover property ($rose(ceBank[0]) && ceStbyOe);
   cover property ($rose(cpuGrant));
   cover property ($fell(readWrite) && chipSelN && ceClkOe);
endmodule : drpf_refresh_ctrl_chk

bind drpf_refresh_ctrl drpf_refresh_ctrl_chk #(
   .PRETRIG_CYCLES(PRETRIG_CYCLES),
   .STROBE_CYCLES(STROBE_CYCLES)
) drpf_refresh_ctrl_chk_inst (
   .clk(clk),
   .rst(rst),
   .refreshClk(refreshClk),
   .cpuGrant(cpuGrant),
   .memAddr(memAddr),
   .ceBank(ceBank),
   .ceStbyOe(ceStbyOe),
   .ceClkOe(ceClkOe),
   .readWrite(readWrite),
   .chipSelN(chipSelN),
   .auxPowerEn(auxPowerEn)
);

// ===== sim/drpf_dram_model.sv
`timescale 1ns/1ps
// bank of single-clock dynamic parts; counts completed row write-backs
module drpf_dram_model (
   // clock
   input wire logic clk,
   // array pins
   input wire logic [1:0] ceBank,
   input wire logic [11:0] memAddr,
   input wire logic readWrite,
   input wire logic chipSelN,
   // bench side
   input wire logic clrMask,
   output int count,
   output int idle,
   output logic [31:0] rowMask,
   output logic [6:0] lastUpper
);
   logic [11:0] latched;
   logic ceWas;
   logic wroteBack;
   // no data pins here, so nothing is ever driven back
   initial begin
      count = 0;
      idle = 0;
      rowMask = 32'h0000_0000;
      lastUpper = 7'h00;
      ceWas = 1'b0;
      wroteBack = 1'b0;
   end
   // address taken on strobe rise, row counts only if written back
   always @(posedge clk) begin
      ceWas <= |ceBank;
      idle <= idle + 1;
      if (clrMask) begin
         rowMask <= 32'h0000_0000;
      end
      if (|ceBank && !ceWas) begin
         latched <= memAddr;
         idle <= 0;
         wroteBack <= 1'b0;
      end else if (|ceBank && !readWrite && chipSelN) begin
         wroteBack <= 1'b1;
      end else if (!(|ceBank) && ceWas && wroteBack) begin
         count <= count + 1;
         rowMask[latched[4:0]] <= 1'b1;
         lastUpper <= latched[11:5];
      end
   end
endmodule : drpf_dram_model

// ===== sim/test_drpf_refresh_ctrl.sv
`timescale 1ns/1ps
module test_drpf_refresh_ctrl;
   localparam int DIST = 200;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} drpf_row_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout;
   logic [1:0] mcnt = 2'b00;
   logic refreshClk = 1'b0;
   logic supplyLoss = 1'b0;
   logic cpuReq = 1'b0;
   logic cpuWrite = 1'b1;
   logic [12:0] cpuAddr = 13'h0000;
   logic cpuGrant, ceStbyOe, ceClkOe, readWrite, chipSelN, auxPowerEn, clrMask;
   logic [11:0] memAddr;
   logic [1:0] ceBank, seen;
   logic [31:0] rd, mMask;
   logic [6:0] mUpper;
   logic [4:0] r;
   int mCount, mIdle, c0, n, cyc, n_mismatch, checks;
   drpf_row_type rows [7] = '{
      '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_0001},
      '{1'b0, 8'h08, 32'h0000_0000, 32'h0000_0000},
      '{1'b1, 8'h08, 32'h0000_0055, 32'h0000_0000},
      '{1'b0, 8'h08, 32'h0000_0000, 32'h0000_0055},
      '{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h06, 32'h0000_0000, 32'h0000_0000},
      '{1'b0, 8'h0C, 32'h0000_0000, 32'h0000_0000}};

   drpf_refresh_ctrl #(.DIST_CYCLES(DIST), .BURST_CYCLES(3000), .PRETRIG_CYCLES(10),
      .STROBE_CYCLES(4)) drpf_refresh_ctrl_inst (
      .clk(clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(), .memClk(mcnt[1]), .refreshClk(refreshClk),
      .supplyLoss(supplyLoss), .cpuReq(cpuReq), .cpuWrite(cpuWrite), .cpuAddr(cpuAddr),
      .cpuGrant(cpuGrant), .memAddr(memAddr), .ceBank(ceBank), .ceStbyOe(ceStbyOe),
      .ceClkOe(ceClkOe), .readWrite(readWrite), .chipSelN(chipSelN), .auxPowerEn(auxPowerEn));
   drpf_dram_model drpf_dram_model_inst (
      .clk(clk), .ceBank(ceBank), .memAddr(memAddr), .readWrite(readWrite),
      .chipSelN(chipSelN), .clrMask(clrMask), .count(mCount), .idle(mIdle),
      .rowMask(mMask), .lastUpper(mUpper));

   // 125 MHz clock; memory clock at a quarter of it
   always #4 clk = ~clk;
   always @(posedge clk) mcnt <= mcnt + 2'b01;
   // hang guard, well above the expected run of about 13000 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // single word transfer; waits on ready, never on a fixed count
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      // read data is picked up while it stands, ahead of the edge that ends the phase
      do begin
         @(negedge clk);
         rd = hrdata;
         @(posedge clk);
      end while (hreadyout !== 1'b1);
   endtask : bus
   task automatic cycles(input int k);
      repeat (k) @(negedge clk);
   endtask : cycles
   task automatic wait_start();
      do @(negedge clk); while (mIdle != 0);
   endtask : wait_start
   task automatic summarize();
      if (n_mismatch == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize

   initial begin
      clrMask = 1'b0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (rows[i]) begin
         bus(rows[i].wr, rows[i].a, rows[i].d);
         if (!rows[i].wr) begin
            chk(rd, rows[i].e);
         end
      end
      // distributed: one row per interval, all rows in 32 intervals
      wait_start();
      c0 = mCount;
      @(posedge clk) clrMask <= 1'b1;
      @(posedge clk) clrMask <= 1'b0;
      cycles(32 * DIST);
      chk(mCount - c0, 32);
      chk(mMask, 32'hFFFF_FFFF);
      chk(mUpper, 7'h55);
      // processor request arriving mid-refresh, bank B only
      wait_start();
      @(posedge clk) cpuReq <= 1'b1;
      cpuAddr <= 13'h1123;
      cycles(3);
      chk(cpuGrant, 1'b0);
      n = 0;
      while (cpuGrant !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      chk(n < 100, 1'b1);
      seen = 2'b00;
      repeat (16) begin
         @(negedge clk);
         seen = seen | ceBank;
      end
      chk(seen, 2'b10);
      @(posedge clk) cpuReq <= 1'b0;
      // burst: 32 back to back after a quiet gap
      bus(1'b1, 8'h00, 32'h0000_0003);
      do @(negedge clk); while (mIdle < 300);
      wait_start();
      c0 = mCount;
      cycles(2900);
      chk(mCount - c0, 32);
      // abort inside the read half: no write-back, row kept
      bus(1'b1, 8'h00, 32'h0000_0001);
      wait_start();
      r = memAddr[4:0];
      c0 = mCount;
      bus(1'b1, 8'h00, 32'h0000_0005);
      // the cut cycle is retried on the same row once precharge is over
      wait_start();
      chk(mCount - c0, 0);
      chk(memAddr[4:0], r);
      bus(1'b0, 8'h04, 32'h0000_0000);
      chk(rd[3], 1'b1);
      bus(1'b1, 8'h00, 32'h0000_0009);
      // supply loss: standby, refresh-only, strobe from refresh clock
      @(posedge clk) supplyLoss <= 1'b1;
      cycles(100);
      chk(ceStbyOe, 1'b1);
      chk(auxPowerEn, 1'b0);
      @(posedge clk) cpuReq <= 1'b1;
      cycles(3);
      chk(cpuGrant, 1'b0);
      @(posedge clk) cpuReq <= 1'b0;
      c0 = mCount;
      @(posedge clk) refreshClk <= 1'b1;
      cycles(20);
      @(posedge clk) refreshClk <= 1'b0;
      cycles(20);
      chk(mCount - c0, 1);
      // supply returns during the pretrigger: switch waits for strobe end
      @(posedge clk) refreshClk <= 1'b1;
      cycles(2);
      @(posedge clk) supplyLoss <= 1'b0;
      cycles(4);
      chk(ceStbyOe, 1'b1);
      @(posedge clk) refreshClk <= 1'b0;
      cycles(40);
      chk(ceStbyOe, 1'b0);
      // reset in mid-run
      @(posedge clk) rst <= 1'b1;
      cycles(2);
      chk({ceBank, readWrite, chipSelN, ceClkOe, ceStbyOe, memAddr}, 18'h0_E000);
      @(posedge clk) rst <= 1'b0;
      summarize();
   end
endmodule : test_drpf_refresh_ctrl
